// ### hdl/fscp_pkg.sv
// Package for the filter serial control port: frame layout, register
// indices, field positions, reset values and timing counts.
// Assumes a single 50 MHz system clock.
package fscp_pkg;

   // Frame layout
   localparam int FRAME_BITS      = 32;
   localparam int DATA_BITS       = 24;
   localparam int ADDR_BITS       = 5;
   localparam int CHIP_BITS       = 3;
   localparam int CNT_W           = 6;

   // Timing
   localparam int  CLK_HZ         = 50_000_000;
   localparam real POR_TIME_US    = 250.0;
   localparam int  POR_CYCLES     = int'(POR_TIME_US * CLK_HZ / 1.0e6);
   localparam int  CAL_TIME_CYC   = 64;
   localparam int  OTP_PULSE_CYC  = 32;

   // Register indices
   localparam logic [4:0] REG_RDSEL   = 5'h00;
   localparam logic [4:0] REG_ENABLE  = 5'h01;
   localparam logic [4:0] REG_SETTING = 5'h02;
   localparam logic [4:0] REG_CALOVR  = 5'h03;
   localparam logic [4:0] REG_CALGO   = 5'h04;
   localparam logic [4:0] REG_CALCLK  = 5'h05;
   localparam logic [4:0] REG_CALRES  = 5'h08;
   localparam logic [4:0] REG_OTPMODE = 5'h0B;
   localparam logic [4:0] REG_OTPIDX  = 5'h0C;
   localparam logic [4:0] REG_OTPGO   = 5'h0D;

   // Field positions
   localparam int EN_CAL_BIT     = 1;
   localparam int EN_FORCE_BIT   = 4;
   localparam int EN_DOUBLER_BIT = 5;
   localparam int RES_OTP_BUSY   = 5;
   localparam int OTPMODE_BIT    = 0;

   // Soft clear sequence and reset values
   localparam logic [23:0] SOFT_ARM_VAL  = 24'h000020;
   localparam logic [23:0] SOFT_FIRE_VAL = 24'h000000;
   localparam logic [23:0] ENABLE_RST    = 24'h00000C;
   localparam logic [23:0] SETTING_RST   = 24'h000009;
   localparam logic [23:0] ZERO_RST      = 24'h000000;

   // One received frame
   typedef struct packed {
      logic [DATA_BITS-1:0] data_field;
      logic [ADDR_BITS-1:0] reg_addr_field;
      logic [CHIP_BITS-1:0] chip_addr_field;
   } frame_type;

endpackage

// ### hdl/filter_serial_control_port.sv
// Serial control port of a dual low-pass filter with its register file,
// calibration and one-time-programmable memory sequencing.
// Assumes serial pins are asynchronous to i_clk and far slower than it.
`timescale 1ns/1ps
module filter_serial_control_port
   import fscp_pkg::*;
#(
   parameter logic [2:0] CHIP_ID    = 3'h2,   // Arbitrary value
   parameter int         POR_CYC    = POR_CYCLES,
   parameter logic [15:0] OTP_RESET = 16'h0000
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_sck,
   input  wire logic        i_frame_enable_n,
   input  wire logic        i_sdi,
   input  wire logic [23:0] i_cal_measure,
   output logic             o_sdo,
   output logic             o_sdo_oe,
   output logic             o_ready,
   output logic [23:0]      o_enable,
   output logic [23:0]      o_setting,
   output logic [3:0]       o_fine_code,
   output logic             o_cal_busy,
   output logic             o_otp_pulse,
   output logic [15:0]      o_otp_bits
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } frame_state_type;

   // Pin synchronisers; first stage read only by the second
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic       sck_prev_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Idle pin levels, so no false clock edge follows reset
         sync1_ff    <= 3'h2;
         sync2_ff    <= 3'h2;
         sck_prev_ff <= 1'b0;
      end else begin
         sync1_ff    <= {i_sck, i_frame_enable_n, i_sdi};
         sync2_ff    <= sync1_ff;
         sck_prev_ff <= sync2_ff[2];
      end
   end

   logic sck_s;
   logic sen_n_s;
   logic sdi_s;
   logic sck_rise;
   assign sck_s    = sync2_ff[2];
   assign sen_n_s  = sync2_ff[1];
   assign sdi_s    = sync2_ff[0];
   assign sck_rise = sck_s & ~sck_prev_ff;

   // Power-on delay: registers held at defaults until it expires
   logic [31:0] por_cnt_ff;
   logic        ready_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         por_cnt_ff <= 32'h0;
         ready_ff   <= 1'b0;
      end else if (!ready_ff) begin
         por_cnt_ff <= por_cnt_ff + 32'h1;
         ready_ff   <= (por_cnt_ff >= 32'(POR_CYC - 1));
      end
   end

   // Frame receiver
   frame_state_type state_ff;
   logic [31:0]     shift_in_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic            commit_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff    <= ST_IDLE;
         shift_in_ff <= 32'h0;
         cnt_ff      <= '0;
         commit_ff   <= 1'b0;
      end else begin
         commit_ff <= 1'b0;
         unique case (state_ff)
            ST_IDLE: begin
               cnt_ff <= '0;
               if (!sen_n_s)
                  state_ff <= ST_SHIFT;
            end
            ST_SHIFT: begin
               if (sen_n_s) begin
                  state_ff <= ST_IDLE;
               end else if (sck_rise) begin
                  // Sample on rising edges, MSB first
                  shift_in_ff <= {shift_in_ff[30:0], sdi_s};
                  cnt_ff      <= cnt_ff + 1'b1;
                  if (cnt_ff == CNT_W'(FRAME_BITS - 1))
                     state_ff <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Extra edges before enable rises spoil the frame
               if (sck_rise) begin
                  state_ff <= ST_IDLE;
               end else if (sen_n_s) begin
                  state_ff  <= ST_IDLE;
                  commit_ff <= 1'b1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   frame_type rx;
   logic      own;
   logic      wr;
   assign rx  = frame_type'(shift_in_ff);
   assign own = (rx.chip_addr_field == CHIP_ID);
   assign wr  = commit_ff & own & ready_ff;

   function automatic logic hit(input logic [4:0] a);
      return wr && (rx.reg_addr_field == a);
   endfunction

   // Register file; soft clear arms on 20h and fires on following 00h
   logic [23:0] rdsel_ff;
   logic [23:0] enable_ff;
   logic [23:0] setting_ff;
   logic [23:0] calovr_ff;
   logic [23:0] calclk_ff;
   logic [23:0] otpidx_ff;
   logic        otpmode_ff;
   logic        soft_arm_ff;
   logic        soft_fire;
   // Operands spelled out: reads hidden in a function would not wake it
   assign soft_fire = soft_arm_ff & wr & (rx.reg_addr_field == REG_RDSEL) &
                      (rx.data_field == SOFT_FIRE_VAL);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdsel_ff    <= ZERO_RST;
         enable_ff   <= ENABLE_RST;
         setting_ff  <= SETTING_RST;
         calovr_ff   <= ZERO_RST;
         calclk_ff   <= ZERO_RST;
         otpidx_ff   <= ZERO_RST;
         otpmode_ff  <= 1'b0;
         soft_arm_ff <= 1'b0;
      end else if (!ready_ff || soft_fire) begin
         rdsel_ff    <= ZERO_RST;
         enable_ff   <= ENABLE_RST;
         setting_ff  <= SETTING_RST;
         calovr_ff   <= ZERO_RST;
         calclk_ff   <= ZERO_RST;
         otpidx_ff   <= ZERO_RST;
         otpmode_ff  <= 1'b0;
         soft_arm_ff <= 1'b0;
      end else if (wr) begin
         unique case (rx.reg_addr_field)
            REG_RDSEL: begin
               rdsel_ff    <= rx.data_field;
               soft_arm_ff <= (rx.data_field == SOFT_ARM_VAL);
            end
            REG_ENABLE:  enable_ff  <= rx.data_field;
            REG_SETTING: setting_ff <= rx.data_field;
            REG_CALOVR:  calovr_ff  <= rx.data_field;
            REG_CALCLK:  calclk_ff  <= rx.data_field;
            REG_OTPMODE:
               otpmode_ff <= rx.data_field[OTPMODE_BIT];
            REG_OTPIDX:  otpidx_ff  <= rx.data_field;
            default: ;
         endcase
      end
   end

   // Calibration: start strobe, fixed-length measure, result capture
   logic [7:0]  cal_cnt_ff;
   logic        cal_busy_ff;
   logic [23:0] cal_res_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cal_cnt_ff  <= 8'h0;
         cal_busy_ff <= 1'b0;
         cal_res_ff  <= 24'h0;
      end else if (!ready_ff || soft_fire) begin
         cal_busy_ff <= 1'b0;
         cal_res_ff  <= 24'h0;
      end else if (cal_busy_ff) begin
         cal_cnt_ff <= cal_cnt_ff - 8'h1;
         if (cal_cnt_ff == 8'h1) begin
            cal_busy_ff <= 1'b0;
            cal_res_ff  <= i_cal_measure;
         end
      end else if (hit(REG_CALGO) && enable_ff[EN_CAL_BIT]) begin
         cal_busy_ff <= 1'b1;
         cal_cnt_ff  <= 8'(CAL_TIME_CYC);
      end
   end

   // OTP program pulse; bits survive soft clear as they are permanent
   logic [7:0]  otp_cnt_ff;
   logic        otp_pulse_ff;
   logic [15:0] otp_bits_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         otp_cnt_ff   <= 8'h0;
         otp_pulse_ff <= 1'b0;
         otp_bits_ff  <= 16'h0;
      end else if (!ready_ff) begin
         otp_bits_ff  <= OTP_RESET;
      end else if (otp_pulse_ff) begin
         otp_cnt_ff <= otp_cnt_ff - 8'h1;
         if (otp_cnt_ff == 8'h1) begin
            otp_pulse_ff <= 1'b0;
            otp_bits_ff[otpidx_ff[3:0]] <= 1'b1;
         end
      end else if (hit(REG_OTPGO) && otpmode_ff) begin
         otp_pulse_ff <= 1'b1;
         otp_cnt_ff   <= 8'(OTP_PULSE_CYC);
      end
   end

   // Read mux for the selected register
   function automatic logic [23:0] rd_mux(input logic [4:0] a);
      unique case (a)
         REG_RDSEL:   rd_mux = rdsel_ff;
         REG_ENABLE:  rd_mux = enable_ff;
         REG_SETTING: rd_mux = setting_ff;
         REG_CALOVR:  rd_mux = calovr_ff;
         REG_CALCLK:  rd_mux = calclk_ff;
         REG_CALRES:  rd_mux = {cal_res_ff[23:6], otp_pulse_ff,
                               cal_res_ff[4:0]};
         REG_OTPMODE: rd_mux = {23'h0, otpmode_ff};
         REG_OTPIDX:  rd_mux = otpidx_ff;
         default:     rd_mux = 24'h0;
      endcase
   endfunction

   // Output shifter: loaded when any frame starts, shifts on rising
   logic [31:0] shift_out_ff;
   logic        sdo_oe_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_out_ff <= 32'h0;
         sdo_oe_ff    <= 1'b0;
      end else begin
         if (state_ff == ST_IDLE && !sen_n_s)
            shift_out_ff <= {rd_mux(rdsel_ff[4:0]), rdsel_ff[4:0],
                             CHIP_ID};
         // MSB stands through the first rise; later rises move on
         else if (state_ff == ST_SHIFT && sck_rise && cnt_ff != '0)
            shift_out_ff <= {shift_out_ff[30:0], 1'b0};
         // Drive follows the chip address of each accepted frame
         if (commit_ff && ready_ff)
            sdo_oe_ff <= own;
      end
   end

   // Output assignments and fine code selection
   assign o_sdo       = shift_out_ff[31];
   assign o_sdo_oe    = sdo_oe_ff;
   assign o_ready     = ready_ff;
   assign o_enable    = enable_ff;
   assign o_setting   = setting_ff;
   // Forced codes take the serial value, else the calibrated result
   logic [3:0] fine_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         fine_ff <= 4'h0;
      else
         fine_ff <= enable_ff[EN_FORCE_BIT] ? calovr_ff[3:0]
                                            : cal_res_ff[3:0];
   end
   assign o_fine_code = fine_ff;
   assign o_cal_busy  = cal_busy_ff;
   assign o_otp_pulse = otp_pulse_ff;
   assign o_otp_bits  = otp_bits_ff;

endmodule

// ### sim/fscp_monitor.sv
// Checker on the serial control port's top-level ports.
// Assumes it is bound to the port block and sees its ports only.
`timescale 1ns/1ps
module fscp_monitor
   import fscp_pkg::*;
#(
   parameter int POR_CYC = POR_CYCLES
) (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_frame_enable_n,
   input wire logic        o_sdo_oe,
   input wire logic        o_ready,
   input wire logic [23:0] o_enable,
   input wire logic [23:0] o_setting,
   input wire logic        o_cal_busy,
   input wire logic        o_otp_pulse,
   input wire logic [15:0] o_otp_bits
);
   logic [15:0] por_cnt_ff;
   logic [7:0]  cal_cnt_ff;
   logic [7:0]  otp_cnt_ff;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Run lengths; a level's run is judged where it falls
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         por_cnt_ff <= '0;
         cal_cnt_ff <= '0;
         otp_cnt_ff <= '0;
      end else begin
         por_cnt_ff <= por_cnt_ff + {15'h0, por_cnt_ff != 16'hFFFF};
         cal_cnt_ff <= o_cal_busy ? cal_cnt_ff + 8'h1 : 8'h0;
         otp_cnt_ff <= o_otp_pulse ? otp_cnt_ff + 8'h1 : 8'h0;
      end
   end
   a_ready_early: assert property (
      o_ready |-> por_cnt_ff >= POR_CYC)
      else $error("ready before power-on delay");
   a_por_defaults: assert property (
      !o_ready |-> o_enable == ENABLE_RST && o_setting == SETTING_RST)
      else $error("registers not at defaults before ready");
   a_cal_length: assert property (
      $fell(o_cal_busy) |-> cal_cnt_ff == CAL_TIME_CYC)
      else $error("calibration length wrong");
   a_cal_gated: assert property (
      $rose(o_cal_busy) |-> o_enable[EN_CAL_BIT])
      else $error("calibration without enable");
   a_otp_length: assert property (
      $fell(o_otp_pulse) |-> otp_cnt_ff == OTP_PULSE_CYC)
      else $error("program pulse length wrong");
   a_otp_sticky: assert property (
      ($past(o_otp_bits) & ~o_otp_bits) == 16'h0)
      else $error("programmed bit cleared");
   a_otp_by_pulse: assert property (
      $changed(o_otp_bits) |-> o_otp_pulse || $past(o_otp_pulse))
      else $error("bit programmed without pulse");
   a_cfg_at_end: assert property (
      $changed({o_enable, o_setting}) |-> $past(i_frame_enable_n, 2))
      else $error("configuration changed inside frame");
   a_oe_at_end: assert property (
      $changed(o_sdo_oe) |-> $past(i_frame_enable_n, 2))
      else $error("output enable changed inside frame");
endmodule

// ### sim/fscp_host.sv
// Host controller model: master of the serial link.
// Assumes the bench calls xfer; clock stands low between frames.
`timescale 1ns/1ps
module fscp_host #(
   parameter time HALF = 80
) (
   output logic      o_sck,
   output logic      o_frame_enable_n,
   output logic      o_sdi,
   input  wire logic i_sdo
);
   initial begin
      o_sck = 1'b0;
      o_frame_enable_n = 1'b1;
      o_sdi = 1'b0;
   end
   // One frame of n bits, MSB first
   task automatic xfer(input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
      rx = '0;
      o_frame_enable_n = 1'b0;
      o_sdi = tx[31];
      #(HALF);
      for (int i = 0; i < n; i++) begin
         o_sck = 1'b1;
         #(HALF);
         o_sck = 1'b0;
         rx = {rx[30:0], i_sdo}; // Read back on fall
         if (i < 31) o_sdi = tx[30-i]; // Change on fall
         #(HALF);
      end
      o_frame_enable_n = 1'b1; // After last fall
      o_sdi = ~o_sdi; // Released line shows no stale bit
      #(HALF * 4);
   endtask
endmodule

// ### sim/tb_filter_serial_control_port.sv
// Bench for the serial control port, with a host model on the link.
// Assumes a register model here predicts every result.
`timescale 1ns/1ps
module tb_filter_serial_control_port;
   import fscp_pkg::*;
   localparam logic [2:0] ID  = 3'h2; // Arbitrary chip identity
   localparam int         POR = 20;
   localparam time        DLY = 3;
   logic        clk = 1'b0;
   logic        rst_n, sck, fen_n, sdi, sdo, sdo_oe, ready;
   logic        cal_busy, otp_pulse, moe, arm, mbusy;
   logic [23:0] cal_meas, enable, setting, mcal;
   logic [15:0] otp_bits, motp, mnext;
   logic [3:0]  fine;
   logic [4:0]  rdsel;
   logic [4:0]  wa [6] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h0B, 5'h0C};
   logic [4:0]  ra [8] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h08, 5'h0B,
                           5'h0C, 5'h1F};
   int          mreg [32];
   int          bad_count = 0;
   int          comparisons = 0;
   int          seed = 32'h95FE0A5A;
   always #10 clk = ~clk;
   filter_serial_control_port #(.CHIP_ID(ID), .POR_CYC(POR)) i_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_sck(sck), .i_frame_enable_n(fen_n),
      .i_sdi(sdi), .i_cal_measure(cal_meas), .o_sdo(sdo),
      .o_sdo_oe(sdo_oe), .o_ready(ready), .o_enable(enable),
      .o_setting(setting), .o_fine_code(fine), .o_cal_busy(cal_busy),
      .o_otp_pulse(otp_pulse), .o_otp_bits(otp_bits));
   fscp_host i_host (.o_sck(sck), .o_frame_enable_n(fen_n), .o_sdi(sdi),
                     .i_sdo(sdo_oe ? sdo : 1'bz));
   task automatic chk_out(input logic [31:0] got, want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: port %h expected %h", $time, got, want);
      end
   endtask
   task automatic chk_rd(input logic [31:0] got, want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("Error at %0t: readback %h expected %h", $time, got, want);
      end
   endtask
   // Defaults; programmed memory bits survive
   task automatic mdef();
      mreg = '{default: 0};
      mreg[1] = 32'h0C;
      mreg[2] = 32'h09;
      mcal = '0;
      rdsel = '0;
   endtask
   function automatic logic [23:0] mrd(input logic [4:0] a);
      case (a)
         5'h01, 5'h02, 5'h03, 5'h05, 5'h0C: return mreg[a][23:0];
         5'h0B: return {23'h0, mreg[a][0]};
         5'h08: return {mcal[23:6], mbusy, mcal[4:0]};
         default: return 24'h0;
      endcase
   endfunction
   // One frame, then the model and the enable, setting, memory, drive and fine-code results
   task automatic wr(input logic [4:0] a, input logic [23:0] d,
                     input logic [2:0] c, input int n);
      logic [31:0] rx;
      logic [31:0] want;
      logic        own;
      want = {mrd(rdsel), rdsel, ID};
      own = (n == 32) && (c == ID);
      @(posedge clk);
      #(DLY);
      i_host.xfer({d, a, c}, n, rx);
      if (moe && rdsel != 5'h0 && n == 32)
         chk_rd(rx, want);
      // A pulse launched before this frame has ended by now
      motp = mnext;
      mbusy = 1'b0;
      if (own && a == 5'h0) begin
         if (arm && d == SOFT_FIRE_VAL) mdef();
         arm = (d == SOFT_ARM_VAL);
         rdsel = d[4:0];
      end else if (own) mreg[a] = d;
      if (n == 32) moe = own;
      if (own && a == REG_CALGO) begin
         chk_out(cal_busy, mreg[1][1]);
         repeat (80) @(posedge clk);
         if (mreg[1][1]) mcal = cal_meas;
      end
      if (own && a == REG_OTPGO) begin
         chk_out(otp_pulse, mreg[11][0]);
         // Bit lands as the pulse ends, inside the following frame
         mbusy = mreg[11][0];
         if (mbusy) mnext[mreg[12][3:0]] = 1'b1;
      end
      chk_out(enable, mreg[1]);
      chk_out(setting, mreg[2]);
      chk_out(otp_bits, motp);
      chk_out(sdo_oe, moe);
      chk_out(fine, mreg[1][4] ? mreg[3][3:0] : mcal[3:0]);
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      cal_meas = 24'($random(seed));
      moe = 1'b0;
      arm = 1'b0;
      motp = '0;
      mnext = '0;
      mbusy = 1'b0;
      mdef();
      repeat (6) @(posedge clk);
      chk_out(enable, ENABLE_RST);
      #(DLY);
      rst_n = 1'b1;
      chk_out(ready, 1'b0);
      repeat (POR + 6) @(posedge clk);
      chk_out(ready, 1'b1);
      $display("Test reset done");
      for (int i = 0; i < 18; i++) begin
         wr(wa[i % 6], 24'($random(seed)), ID, 32);
         wr(5'h0, {19'h0, ra[$random(seed) & 7]}, ID, 32);
      end
      $display("Test writes and reads done");
      wr(5'h1, 24'($random(seed)), ID ^ 3'h5, 32);
      wr(5'h0, 24'h2, ID, 32);
      wr(5'h2, 24'($random(seed)), ID, 31);
      wr(5'h0, 24'h2, ID, 32);
      wr(5'h2, 24'($random(seed)), ID, 33);
      wr(5'h0, 24'h2, ID, 32);
      $display("Test refused frames done");
      wr(5'h1, 24'h0, ID, 32);
      wr(REG_CALGO, 24'h0, ID, 32);
      wr(5'h1, 24'h22, ID, 32);
      wr(REG_CALGO, 24'($random(seed)), ID, 32);
      wr(5'h0, 24'h8, ID, 32);
      wr(5'h0, 24'h3, ID, 32);
      wr(5'h1, 24'h12, ID, 32);
      $display("Test calibration done");
      // Mode cleared first: random writes may have left it set
      wr(REG_OTPMODE, 24'h0, ID, 32);
      wr(REG_OTPGO, 24'h0, ID, 32);
      wr(REG_OTPMODE, 24'h1, ID, 32);
      wr(REG_RDSEL, 24'h8, ID, 32);
      // Index frame reads the busy flag low before each strobe
      for (int i = 0; i < 3; i++) begin
         wr(REG_OTPIDX, {20'h0, 4'(i * 15)}, ID, 32);
         wr(REG_OTPGO, 24'($random(seed)), ID, 32);
         wr(REG_RDSEL, 24'h8, ID, 32);
      end
      wr(REG_OTPMODE, 24'h0, ID, 32);
      $display("Test memory programming done");
      wr(REG_RDSEL, SOFT_ARM_VAL, ID, 32);
      wr(REG_RDSEL, SOFT_FIRE_VAL, ID, 32);
      $display("Test soft clear done");
      end_sim();
   end
   // Frames take about 6 us each; well under a millisecond in all
   initial begin
      #1ms;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule
bind filter_serial_control_port fscp_monitor #(.POR_CYC(POR_CYC)) i_mon (
   .i_clk, .i_rst_n, .i_frame_enable_n, .o_sdo_oe, .o_ready, .o_enable,
   .o_setting, .o_cal_busy, .o_otp_pulse, .o_otp_bits);
